// ==== rtl/clock_reset_control.sv ====
// Clock and reset unit: register file, program timer, 90 kHz tick and clock dividers.
// Assumes a peripheral bus master on ref_clk_i; pll_lock_i comes from another domain.
`include "clock_reset_control_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module clock_reset_control #(
    parameter int TICK_DIV = `PTIMER_CYCLES
) (
    // Clock, reset and freeze.
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Peripheral register bus.
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [9:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Analog status.
    input  wire logic        pll_lock_i,
    // Timer events.
    output logic             timer_irq_o,
    output logic             ninety_khz_tick_o,
    // Generated clocks.
    output logic             main_peripheral_clock_o,
    output logic             audio_clk_o,
    output logic             audio_dac_clk_o,
    output logic             cpu_trace_clk_o,
    output logic             axi_clk_o,
    output logic             apb_clk_o,
    // Clock source selects.
    output logic      [2:0]  sys_clk_source_select_o,
    output logic             divider_mux_pll_o,
    output logic             pll_mux_pll_o,
    output logic             rtc_osc_select_o,
    output logic      [1:0]  audio_dac_source_o,
    output logic             alternate_adc_pll_clock_o,
    // Clock gates and memory power-down.
    output logic      [63:0] main_gate_o,
    output logic      [31:0] main_gate_extra_o,
    output logic      [31:0] other_gate_o,
    output logic      [7:0]  ao_gate_o,
    output logic             interlaced_encoder_clock_gate_o,
    output logic             interlaced_encoder_bist_gate_o,
    output logic      [31:0] mem_pd_o,
    output logic      [63:0] video_mem_pd_o,
    // Processor resets and PLL control.
    output logic      [3:0]  core_reset_n_field_o,
    output logic             level2_cache_reset_n_o,
    output logic             debug_reset_n_o,
    output logic      [3:0]  cpu_soft_reset_o,
    output logic             cpu_axi_reset_o,
    output logic             gp_pll_enable_o,
    output logic             gp_pll_reset_o
);
    import clock_reset_control_pkg::*;

    localparam int PW = $clog2(TICK_DIV);
    localparam int ND = 6;
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_DIV - 1);

    // The prescaler needs at least two states to be meaningful.
    if (TICK_DIV < 2) begin : g_chk
        $error("TICK_DIV must be at least 2");
    end

    // Map a word index to a storage slot; the top bit flags a hit.
    function automatic logic [5:0] decode(input logic [7:0] idx);
        case (idx)
            `IDX_SYS_REF:  decode = {1'b1, S_REF};
            `IDX_PTIMER:   decode = {1'b1, S_PTM};
            `IDX_GPLL0:    decode = {1'b1, S_PLL0};
            `IDX_GPLL2:    decode = {1'b1, S_PLL2};
            `IDX_GPLL3:    decode = {1'b1, S_PLL3};
            `IDX_GPLL4:    decode = {1'b1, S_PLL4};
            `IDX_XTAL_PIN: decode = {1'b1, S_XTAL};
            `IDX_T90K:     decode = {1'b1, S_T90K};
            `IDX_MEM_PD0:  decode = {1'b1, S_MPD0};
            `IDX_VMEM_PD0: decode = {1'b1, S_VPD0};
            `IDX_VMEM_PD1: decode = {1'b1, S_VPD1};
            `IDX_SVID_DIV: decode = {1'b1, S_SVDIV};
            `IDX_SVID_CTL: decode = {1'b1, S_SVCTL};
            `IDX_GATE_LO:  decode = {1'b1, S_GLO};
            `IDX_GATE_HI:  decode = {1'b1, S_GHI};
            `IDX_GATE_EX:  decode = {1'b1, S_GEX};
            `IDX_GATE_OTH: decode = {1'b1, S_GOTH};
            `IDX_GATE_AO:  decode = {1'b1, S_GAO};
            `IDX_OSC_CTL:  decode = {1'b1, S_OSC};
            `IDX_CPU_DIV:  decode = {1'b1, S_CPUD};
            `IDX_CPU_RST:  decode = {1'b1, S_CPUR};
            `IDX_VID_DIV:  decode = {1'b1, S_VDIV};
            `IDX_SYS_CTL:  decode = {1'b1, S_SYS};
            `IDX_AUD_CTL:  decode = {1'b1, S_AUD};
            `IDX_VID_CTL:  decode = {1'b1, S_VCTL};
            default:       decode = 6'h00;
        endcase
    endfunction

    // Reset value of each slot.
    function automatic logic [31:0] reset_of(input slot_t s);
        case (s)
            S_T90K:               reset_of = `RST_T90K;
            S_MPD0, S_VPD0, S_VPD1: reset_of = `RST_MEM_PD;
            S_GAO:                reset_of = `RST_GATE_AO;
            S_OSC:                reset_of = `RST_OSC;
            S_SYS:                reset_of = `RST_SYS_CTL;
            S_AUD:                reset_of = `RST_AUD_CTL;
            default:              reset_of = 32'h0;
        endcase
    endfunction

    // Writable bits of each slot; others read back as stored or zero.
    function automatic logic [31:0] wmask_of(input slot_t s);
        case (s)
            S_PTM:   wmask_of = `WM_PTIMER;
            S_GAO:   wmask_of = `WM_GATE_AO;
            S_OSC:   wmask_of = `WM_OSC;
            S_PLL0:  wmask_of = `WM_GPLL0;
            default: wmask_of = 32'hffffffff;
        endcase
    endfunction

    // Divider counter step: wraps after reaching its limit.
    function automatic div_cnt_t div_next(input div_cnt_t cnt, input div_cnt_t lim);
        div_next = (cnt >= lim) ? 15'h0000 : cnt + 15'h0001;
    endfunction

    // High for the first half of a period of lim+1 cycles.
    function automatic logic div_level(input div_cnt_t cnt, input div_cnt_t lim);
        logic [15:0] half;
        half = ({1'b0, lim} + 16'h0002) >> 1;
        div_level = {1'b0, cnt} < half;
    endfunction

    logic [31:0] regs_r [0:`CRC_NUM_REGS-1];
    logic [31:0] rd_val;
    logic [31:0] wmask;
    logic [5:0]  dec;
    logic        hit;
    logic        access;
    logic        wr_en;
    slot_t       slot;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic        lock_s1_r;
    logic        lock_s2_r;
    logic [PW-1:0] pre_r;
    logic [11:0] ptimer_r;
    logic        timer_irq_r;
    logic [15:0] n90_cnt_r;
    logic        n90_tick_r;
    div_cnt_t    cnt_r [0:ND-1];
    div_cnt_t    lim [0:ND-1];
    logic [ND-1:0] run;
    logic [ND-1:0] clk_r;

    // Word index decode; the two low address bits select nothing.
    assign dec    = decode(paddr_i[9:2]);
    assign hit    = dec[5];
    assign slot   = slot_t'(dec[4:0]);
    assign access = psel_i & penable_i & ~pready_r;
    assign wr_en  = access & pwrite_i & hit;
    assign wmask  = wmask_of(slot);

    // Read view; the timer and the lock flag live outside the array.
    always_comb begin
        case (slot)
            S_PTM:   rd_val = {20'h00000, ptimer_r};
            S_PLL0:  rd_val = {lock_s2_r, regs_r[S_PLL0][30:0]};
            default: rd_val = regs_r[slot];
        endcase
    end

    // Lock flag crosses from the analog side through two flops.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
        end else if (ce_i) begin
            lock_s1_r <= pll_lock_i;
            lock_s2_r <= lock_s1_r;
        end
    end

    // Bus answer: one wait state, so every output comes from a flop.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else if (ce_i) begin
            pready_r  <= access;
            pslverr_r <= access & ~hit;
            if (access & ~pwrite_i) begin
                prdata_r <= hit ? rd_val : 32'h0;
            end
        end
    end

    // Register file; masked bits keep their value on a write.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `CRC_NUM_REGS; i++) begin
                regs_r[i] <= reset_of(slot_t'(i[4:0]));
            end
        end else if (ce_i && wr_en) begin
            regs_r[slot] <= (pwdata_i & wmask) | (regs_r[slot] & ~wmask);
        end
    end

    // Program timer; a software write wins over a prescaler step.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pre_r       <= '0;
            ptimer_r    <= 12'h000;
            timer_irq_r <= 1'b0;
        end else if (ce_i) begin
            timer_irq_r <= 1'b0;
            pre_r <= (pre_r == PRE_LAST) ? '0 : pre_r + 1'b1;
            if (wr_en && slot == S_PTM) begin
                ptimer_r <= pwdata_i[`PTIMER_CNT];
            end else if (pre_r == PRE_LAST) begin
                ptimer_r <= ptimer_r + 12'h001;
                if (ptimer_r == `PTIMER_TOP) begin
                    timer_irq_r <= 1'b1;
                end
            end
        end
    end

    // 90 kHz tick: one pulse per programmed number of cycles.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            n90_cnt_r  <= 16'h0000;
            n90_tick_r <= 1'b0;
        end else if (ce_i) begin
            if ({1'b0, n90_cnt_r} + 17'h00001 >= {1'b0, regs_r[S_T90K][`T90K_VAL]}) begin
                n90_cnt_r  <= 16'h0000;
                n90_tick_r <= 1'b1;
            end else begin
                n90_cnt_r  <= n90_cnt_r + 16'h0001;
                n90_tick_r <= 1'b0;
            end
        end
    end

    // Divider limits and run conditions; a select of zero leaves a CPU clock stopped.
    always_comb begin
        lim[0] = regs_r[S_SYS][`SYS_WIDE_EN] ? regs_r[S_SYS][`SYS_WIDE_DIV]
                                             : {8'h00, regs_r[S_SYS][`SYS_DIV]};
        run[0] = 1'b1;
        lim[1] = {7'h00, regs_r[S_AUD][`AUD_DIV]};
        run[1] = regs_r[S_AUD][`AUD_PLL_EN];
        lim[2] = {8'h00, regs_r[S_AUD][`AUD_DAC_DIV]};
        run[2] = regs_r[S_AUD][`AUD_DAC_EN];
        lim[3] = {12'h000, regs_r[S_CPUD][`CPU_TRC_SEL]};
        run[3] = ~regs_r[S_CPUD][`CPU_TRC_BLK] & (|regs_r[S_CPUD][`CPU_TRC_SEL]);
        lim[4] = {12'h000, regs_r[S_CPUD][`CPU_AXI_SEL]};
        run[4] = ~regs_r[S_CPUD][`CPU_AXI_BLK] & (|regs_r[S_CPUD][`CPU_AXI_SEL]);
        lim[5] = {12'h000, regs_r[S_CPUD][`CPU_APB_SEL]};
        run[5] = ~regs_r[S_CPUD][`CPU_APB_BLK] & (|regs_r[S_CPUD][`CPU_APB_SEL]);
    end

    // Divider counters; a limit lowered mid-period restarts cleanly.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < ND; i++) begin
                cnt_r[i] <= 15'h0000;
            end
            clk_r <= '0;
        end else if (ce_i) begin
            for (int i = 0; i < ND; i++) begin
                if (run[i]) begin
                    cnt_r[i] <= div_next(cnt_r[i], lim[i]);
                    clk_r[i] <= div_level(cnt_r[i], lim[i]);
                end else begin
                    cnt_r[i] <= 15'h0000;
                    clk_r[i] <= 1'b0;
                end
            end
        end
    end

    // Bus and event outputs.
    assign prdata_o          = prdata_r;
    assign pready_o          = pready_r;
    assign pslverr_o         = pslverr_r;
    assign timer_irq_o       = timer_irq_r;
    assign ninety_khz_tick_o = n90_tick_r;

    // Generated clock levels.
    assign main_peripheral_clock_o = clk_r[0];
    assign audio_clk_o             = clk_r[1];
    assign audio_dac_clk_o         = clk_r[2];
    assign cpu_trace_clk_o         = clk_r[3];
    assign axi_clk_o               = clk_r[4];
    assign apb_clk_o               = clk_r[5];

    // Source selects drive the clock-tree muxes directly from their flops.
    assign sys_clk_source_select_o   = regs_r[S_SYS][`SYS_SRC];
    assign divider_mux_pll_o         = regs_r[S_SYS][`SYS_DIV_MUX];
    assign pll_mux_pll_o             = regs_r[S_SYS][`SYS_PLL_MUX];
    assign rtc_osc_select_o          = regs_r[S_SYS][`SYS_RTC];
    assign audio_dac_source_o        = regs_r[S_AUD][`AUD_DAC_SRC];
    assign alternate_adc_pll_clock_o = regs_r[S_SVDIV][`SVID_ALT_DAC];

    // Gate enables are high to run a clock; power-down pairs are 11 to sleep.
    assign main_gate_o                     = {regs_r[S_GHI], regs_r[S_GLO]};
    assign main_gate_extra_o               = regs_r[S_GEX];
    assign other_gate_o                    = regs_r[S_GOTH];
    assign ao_gate_o                       = regs_r[S_GAO][7:0];
    assign interlaced_encoder_clock_gate_o = regs_r[S_GOTH][`ENC_GATE_NORM];
    assign interlaced_encoder_bist_gate_o  = regs_r[S_GOTH][`ENC_GATE_BIST];
    assign mem_pd_o                        = regs_r[S_MPD0];
    assign video_mem_pd_o                  = {regs_r[S_VPD1], regs_r[S_VPD0]};

    // Processor resets: the _n fields hold their targets in reset while zero.
    assign core_reset_n_field_o   = regs_r[S_CPUR][`RST_CORE_N];
    assign level2_cache_reset_n_o = regs_r[S_CPUR][`RST_L2_N];
    assign debug_reset_n_o        = regs_r[S_CPUR][`RST_DBG_N];
    assign cpu_soft_reset_o       = regs_r[S_CPUR][`RST_SOFT];
    assign cpu_axi_reset_o        = regs_r[S_CPUR][`RST_CPU_AXI];
    assign gp_pll_enable_o        = regs_r[S_PLL0][`GPLL_EN];
    assign gp_pll_reset_o         = regs_r[S_PLL0][`GPLL_RST];

    // Checks on the block's own registers and outputs.
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    a_unmapped_err: assert property (access && !hit && ce_i |=> pready_r && pslverr_r)
        else $error("unmapped access not refused");
    a_ref_write: assert property (wr_en && ce_i && slot == S_REF |=> regs_r[S_REF] == $past(pwdata_i))
        else $error("reference register write lost");
    a_timer_step: assert property (ce_i && pre_r == PRE_LAST && !(wr_en && slot == S_PTM)
        |=> ptimer_r == 12'($past(ptimer_r) + 12'h001))
        else $error("program timer did not advance");
    // The registered read path is checked, so a wrong concatenation in the read view shows up.
    a_timer_top: assert property (ce_i && access && !pwrite_i && slot == S_PTM
        |=> prdata_r[31:12] == 20'h00000)
        else $error("program timer upper bits not zero");
    // A frozen pulse is only judged on its first cycle; later frozen cycles see a stale history.
    a_timer_irq: assert property (timer_irq_r && $past(ce_i)
        |-> $past(ptimer_r) == `PTIMER_TOP && ptimer_r == 12'h000)
        else $error("timer interrupt without expiry");
    a_pd_reset: assert property ($fell(rst_i) |-> regs_r[S_VPD0] == `RST_MEM_PD)
        else $error("power-down fields not reset to 11");
    a_gate_split: assert property (wr_en && ce_i && slot == S_GHI |=> main_gate_o[63:32] == $past(pwdata_i))
        else $error("upper gating word misplaced");
    a_ao_top: assert property (regs_r[S_GAO][`AO_UNUSED] == 24'h000000)
        else $error("always-on unused bits not zero");
    a_trace_block: assert property (ce_i && regs_r[S_CPUD][`CPU_TRC_BLK] |=> !cpu_trace_clk_o)
        else $error("trace clock runs while blocked");
    a_audio_stop: assert property (ce_i && !regs_r[S_AUD][`AUD_PLL_EN] |=> !audio_clk_o)
        else $error("audio clock runs while disabled");

    c_timer_irq: cover property (timer_irq_r);
    c_main_rise: cover property ($rose(main_peripheral_clock_o));
    c_unmapped: cover property (pready_r && pslverr_r);
    c_audio_rise: cover property ($rose(audio_clk_o));
endmodule
`default_nettype wire

// ==== rtl/clock_reset_control_defines.svh ====
// Register indices, reset values, write masks and field ranges of the clock and reset unit.
// Assumes a register bus that addresses one 32-bit word per index.
`ifndef CLOCK_RESET_CONTROL_DEFINES_SVH
`define CLOCK_RESET_CONTROL_DEFINES_SVH
`define CRC_BASE_ADDR 32'hc883c000
`define CRC_NUM_REGS 25
`define IDX_SYS_REF 8'h0b
`define IDX_PTIMER 8'h0f
`define IDX_GPLL0 8'h10
`define IDX_GPLL2 8'h11
`define IDX_GPLL3 8'h12
`define IDX_GPLL4 8'h13
`define IDX_XTAL_PIN 8'h2f
`define IDX_T90K 8'h3b
`define IDX_MEM_PD0 8'h40
`define IDX_VMEM_PD0 8'h41
`define IDX_VMEM_PD1 8'h42
`define IDX_SVID_DIV 8'h4a
`define IDX_SVID_CTL 8'h4b
`define IDX_GATE_LO 8'h50
`define IDX_GATE_HI 8'h51
`define IDX_GATE_EX 8'h52
`define IDX_GATE_OTH 8'h54
`define IDX_GATE_AO 8'h55
`define IDX_OSC_CTL 8'h56
`define IDX_CPU_DIV 8'h57
`define IDX_CPU_RST 8'h58
`define IDX_VID_DIV 8'h59
`define IDX_SYS_CTL 8'h5d
`define IDX_AUD_CTL 8'h5e
`define IDX_VID_CTL 8'h5f
`define RST_T90K 32'h00000384
`define RST_MEM_PD 32'hffffffff
`define RST_GATE_AO 32'h000000ff
`define RST_OSC 32'h0000ffff
`define RST_SYS_CTL 32'h00006080
`define RST_AUD_CTL 32'h00000001
`define WM_PTIMER 32'h00000000
`define WM_GATE_AO 32'h000000ff
`define WM_OSC 32'h0000ffff
`define WM_GPLL0 32'h7fffffff
`define PTIMER_CYCLES 900
`define PTIMER_CNT 11:0
`define PTIMER_TOP 12'hfff
`define T90K_VAL 15:0
`define GPLL_LOCK 31
`define GPLL_EN 30
`define GPLL_RST 29
`define SYS_WIDE_EN 31
`define SYS_WIDE_DIV 30:16
`define SYS_SRC 14:12
`define SYS_RTC 9
`define SYS_DIV_MUX 8
`define SYS_PLL_MUX 7
`define SYS_DIV 6:0
`define AUD_DAC_SRC 25:24
`define AUD_DAC_EN 23
`define AUD_DAC_DIV 22:16
`define AUD_PLL_EN 8
`define AUD_DIV 7:0
`define CPU_TRC_BLK 23
`define CPU_TRC_SEL 22:20
`define CPU_AXI_BLK 18
`define CPU_AXI_SEL 11:9
`define CPU_APB_BLK 16
`define CPU_APB_SEL 5:3
`define RST_CPU_AXI 10
`define RST_DBG_N 9
`define RST_L2_N 8
`define RST_CORE_N 7:4
`define RST_SOFT 3:0
`define ENC_GATE_NORM 2
`define ENC_GATE_BIST 1
`define SVID_ALT_DAC 19
`define AO_UNUSED 31:8
`endif

// ==== rtl/clock_reset_control_pkg.sv ====
// Types shared by the clock and reset unit.
// Assumes the defines header is compiled alongside.
package clock_reset_control_pkg;
    // Storage slot of each register, in ascending index order.
    typedef enum logic [4:0] {
        S_REF, S_PTM, S_PLL0, S_PLL2, S_PLL3, S_PLL4, S_XTAL, S_T90K, S_MPD0,
        S_VPD0, S_VPD1, S_SVDIV, S_SVCTL, S_GLO, S_GHI, S_GEX, S_GOTH, S_GAO,
        S_OSC, S_CPUD, S_CPUR, S_VDIV, S_SYS, S_AUD, S_VCTL
    } slot_t;
    typedef logic [14:0] div_cnt_t;
endpackage

// ==== sim/clock_reset_control_test.sv ====
// Self-checking bench for the clock and reset unit: registers, timer, tick and divided clocks.
// Assumes the design, package and defines header compile first; inputs change on falling edges.
`include "clock_reset_control_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module clock_reset_control_test;
    import clock_reset_control_pkg::*;
    localparam int TD = 4;
    logic        ref_clk_i, rst_i, ce_i, psel_i, penable_i, pwrite_i, pll_lock_i;
    logic [9:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o, main_gate_extra_o, other_gate_o, mem_pd_o;
    logic        pready_o, pslverr_o, timer_irq_o, ninety_khz_tick_o, main_peripheral_clock_o, audio_clk_o;
    logic        audio_dac_clk_o, cpu_trace_clk_o, axi_clk_o, apb_clk_o, divider_mux_pll_o, pll_mux_pll_o;
    logic        rtc_osc_select_o, alternate_adc_pll_clock_o, interlaced_encoder_clock_gate_o;
    logic        interlaced_encoder_bist_gate_o, level2_cache_reset_n_o, debug_reset_n_o, cpu_axi_reset_o;
    logic        gp_pll_enable_o, gp_pll_reset_o;
    logic [2:0]  sys_clk_source_select_o;
    logic [1:0]  audio_dac_source_o;
    logic [63:0] main_gate_o, video_mem_pd_o;
    logic [7:0]  ao_gate_o;
    logic [3:0]  core_reset_n_field_o, cpu_soft_reset_o;
    logic [7:0]  idx [25] = '{8'h0b, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h2f, 8'h3b, 8'h40, 8'h41, 8'h42,
                              8'h4a, 8'h4b, 8'h50, 8'h51, 8'h52, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59,
                              8'h5d, 8'h5e, 8'h5f};
    logic [31:0] mdl [256];
    logic [31:0] seed = 32'h428aa1a8;
    logic [31:0] rd;
    logic        er;
    int          err_total = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          p, n;

    clock_reset_control #(.TICK_DIV(TD)) dut (.*);

    // Free-running reference clock, 50 ns period.
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    // Enabled edges since reset release, used to place the timer wrap; a frozen edge does not count.
    always @(posedge ref_clk_i) cyc <= rst_i ? 0 : cyc + (ce_i ? 1 : 0);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Writable bits per index; read-only bits keep their model value.
    function automatic logic [31:0] wmask(input logic [7:0] i);
        case (i)
            `IDX_PTIMER:  return 32'h00000000;
            `IDX_GPLL0:   return 32'h7fffffff;
            `IDX_GATE_AO: return 32'h000000ff;
            `IDX_OSC_CTL: return 32'h0000ffff;
            default:      return 32'hffffffff;
        endcase
    endfunction

    function automatic logic sig(input int w);
        case (w)
            0: return main_peripheral_clock_o;
            1: return audio_clk_o;
            2: return audio_dac_clk_o;
            3: return cpu_trace_clk_o;
            4: return axi_clk_o;
            5: return apb_clk_o;
            default: return ninety_khz_tick_o;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One access, entered at a falling edge; request held until the ready cycle is seen.
    task automatic bus(input logic wr, input logic [7:0] i, input logic [31:0] d);
        int k;
        psel_i = 1'b1;
        pwrite_i = wr;
        paddr_i = {i, 2'b00};
        pwdata_i = d;
        @(negedge ref_clk_i);
        penable_i = 1'b1;
        k = 0;
        // Ready is looked at on the rising edge, before the design moves it on.
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 8);
        rd = prdata_o;
        er = pslverr_o;
        chk({31'h0, pready_o}, 32'h1);
        @(negedge ref_clk_i);
        psel_i = 1'b0;
        penable_i = 1'b0;
        @(negedge ref_clk_i);
    endtask

    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        bus(1'b1, i, d);
        mdl[i] = (mdl[i] & ~wmask(i)) | (d & wmask(i));
    endtask

    task automatic rdchk(input logic [7:0] i, input logic unmapped);
        bus(1'b0, i, rnd());
        chk(rd, unmapped ? 32'h0 : mdl[i]);
        chk({31'h0, er}, {31'h0, unmapped});
    endtask

    // Distance between two rising edges; 0 when the signal never rises.
    task automatic period(input int w, output int pr);
        logic prev;
        int e1;
        pr = 0;
        e1 = -1;
        prev = 1'b1;
        for (int k = 0; k < 200 && pr == 0; k++) begin
            @(negedge ref_clk_i);
            if (sig(w) === 1'b1 && !prev) begin
                if (e1 >= 0) pr = k - e1;
                else e1 = k;
            end
            prev = sig(w) === 1'b1;
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog sized well above the timer wrap plus the register tests.
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        err_total++;
        print_verdict();
    end

    initial begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        ce_i = 1'b1;
        pll_lock_i = 1'b0;
        rst_i = 1'b1;
        foreach (mdl[i]) mdl[i] = 32'h0;
        mdl[8'h3b] = 32'h384;
        mdl[8'h40] = 32'hffffffff;
        mdl[8'h41] = 32'hffffffff;
        mdl[8'h42] = 32'hffffffff;
        mdl[8'h55] = 32'hff;
        mdl[8'h56] = 32'hffff;
        mdl[8'h5d] = 32'h6080;
        mdl[8'h5e] = 32'h1;
        repeat (12) @(negedge ref_clk_i);
        rst_i = 1'b0;
        foreach (idx[k]) if (idx[k] != `IDX_PTIMER) rdchk(idx[k], 1'b0);
        chk({29'h0, sys_clk_source_select_o}, 32'h6);
        chk({30'h0, pll_mux_pll_o, ao_gate_o == 8'hff}, 32'h3);
        chk({28'h0, core_reset_n_field_o}, 32'h0);
        rdchk(8'h00, 1'b1);
        rdchk(8'hff, 1'b1);
        $display("reset values and unmapped places done");
        // Random words into every mapped place but the program timer, then read back and mirrored outputs.
        foreach (idx[k]) if (idx[k] != `IDX_PTIMER) wr(idx[k], rnd());
        wr(8'h00, rnd());
        foreach (idx[k]) if (idx[k] != `IDX_PTIMER) rdchk(idx[k], 1'b0);
        rdchk(8'h00, 1'b1);
        chk(main_gate_o[31:0], mdl[8'h50]);
        chk(main_gate_o[63:32], mdl[8'h51]);
        chk(video_mem_pd_o[63:32], mdl[8'h42]);
        chk({interlaced_encoder_clock_gate_o, interlaced_encoder_bist_gate_o}, mdl[8'h54][2:1]);
        chk(alternate_adc_pll_clock_o, mdl[8'h4a][19]);
        chk({rtc_osc_select_o, divider_mux_pll_o, pll_mux_pll_o}, mdl[8'h5d][9:7]);
        chk(audio_dac_source_o, mdl[8'h5e][25:24]);
        chk({debug_reset_n_o, level2_cache_reset_n_o, core_reset_n_field_o}, mdl[8'h58][9:4]);
        chk(main_gate_extra_o, mdl[8'h52]);
        chk(other_gate_o, mdl[8'h54]);
        chk(mem_pd_o, mdl[8'h40]);
        chk(video_mem_pd_o[31:0], mdl[8'h41]);
        chk(ao_gate_o, mdl[8'h55][7:0]);
        chk(sys_clk_source_select_o, mdl[8'h5d][14:12]);
        chk({cpu_axi_reset_o, cpu_soft_reset_o}, {mdl[8'h58][10], mdl[8'h58][3:0]});
        chk({gp_pll_enable_o, gp_pll_reset_o}, mdl[8'h10][30:29]);
        // Lock needs two synchroniser edges before a read can show it.
        pll_lock_i = 1'b1;
        mdl[8'h10][31] = 1'b1;
        @(negedge ref_clk_i);
        rdchk(`IDX_GPLL0, 1'b0);
        $display("register file done");
        // Divided clocks: narrow and wide main divider, audio pair, processor selects.
        for (int d = 1; d <= 5; d += 2) begin
            wr(`IDX_SYS_CTL, 32'h00006000 | d);
            period(0, p);
            chk(p, d + 1);
        end
        wr(`IDX_SYS_CTL, 32'h8007607f);
        period(0, p);
        chk(p, 8);
        wr(`IDX_AUD_CTL, 32'h00850104);
        period(1, p);
        chk(p, 5);
        period(2, p);
        chk(p, 6);
        wr(`IDX_AUD_CTL, 32'h00050004);
        period(1, p);
        chk(p, 0);
        period(2, p);
        chk(p, 0);
        for (int s = 1; s <= 7; s++) begin
            wr(`IDX_CPU_DIV, (s << 20) | (s << 9) | (s << 3));
            for (int w = 3; w <= 5; w++) begin
                period(w, p);
                chk(p, s + 1);
            end
        end
        wr(`IDX_CPU_DIV, 32'h00d50e18);
        for (int w = 3; w <= 5; w++) begin
            period(w, p);
            chk(p, 0);
        end
        wr(`IDX_T90K, 32'h5);
        period(6, p);
        chk(p, 5);
        // With the enable low nothing may move, the tick included.
        ce_i = 1'b0;
        period(6, p);
        chk(p, 0);
        ce_i = 1'b1;
        $display("divided clocks done");
        // The counter wraps after 4096 prescaler periods and must pulse the interrupt once.
        n = 0;
        while (timer_irq_o !== 1'b1 && n < 40000) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk(cyc == 4096 * TD || cyc == 4096 * TD + 1, 1'b1);
        @(negedge ref_clk_i);
        chk(timer_irq_o, 1'b0);
        bus(1'b0, `IDX_PTIMER, 32'h0);
        chk(rd[31:12] == 20'h0 && rd[11:0] <= 12'h2, 1'b1);
        $display("program timer done");
        print_verdict();
    end
endmodule
`default_nettype wire
